// ### include/tsisp_params.svh
// Constants of the two-wire temperature sensor slave port
`ifndef TSISP_PARAMS_SVH
`define TSISP_PARAMS_SVH
`define TSISP_CODE_STD 4'h3
`define TSISP_CODE_ALT 4'h9
`define TSISP_BYTE_BITS 4'h8
`define TSISP_BIT_ZERO 4'h0
`define TSISP_PTR_W 4
`define TSISP_TOUT_MS 25
`define TSISP_CLK_NS 50
`define TSISP_NS_PER_MS 1000000
`endif

// ### include/tsisp_pkg.sv
// Types of the two-wire temperature sensor slave port
package tsisp_pkg;
   typedef logic [3:0] tsisp_ptr_t;
   typedef logic [7:0] tsisp_byte_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } tsisp_state_t;
endpackage

// ### design/tsisp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tsisp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Data
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_q <= '1;
         syncOut <= '1;
      end
      else
      begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule

// ### design/tsisp_slave.sv
// Two-wire slave port of the temperature sensor
`timescale 1ns/10ps
`include "tsisp_params.svh"
module tsisp_slave #(
   parameter bit ALT_CODE = 1'b0,
   parameter int TOUT_CYC = `TSISP_TOUT_MS * (`TSISP_NS_PER_MS / `TSISP_CLK_NS),
   parameter int TOUT_W = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Address straps
   input wire logic addrStrapBit0,
   input wire logic addrStrapBit1,
   input wire logic addrStrapBit2,
   // Alert
   input wire logic overTemp,
   output logic alertOut,
   output logic alertOe,
   // Register side
   output tsisp_pkg::tsisp_ptr_t regPtr,
   output tsisp_pkg::tsisp_byte_t wrData,
   output logic wrStrobe,
   input wire tsisp_pkg::tsisp_byte_t rdByte,
   output logic rdTake
);
   import tsisp_pkg::*;

   localparam logic [TOUT_W-1:0] TOUT_LIM = TOUT_W'(TOUT_CYC);
   localparam logic [3:0] DEV_CODE = ALT_CODE ? `TSISP_CODE_ALT : `TSISP_CODE_STD;

   logic [4:0] syncOut;
   logic sclS, sdaS, sclP_q, sdaP_q;
   logic [2:0] strapS;
   tsisp_state_t state_q, state_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   tsisp_byte_t shift_q, shift_d;
   logic oe_d, firstRx_q, firstRx_d, nak_q, nak_d;
   tsisp_ptr_t ptr_d;
   tsisp_byte_t wrData_d;
   logic wrStb_d, rdTake_d;
   logic [TOUT_W-1:0] toutCnt_q;

   tsisp_sync #(
      .W(5)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn({sclIn, sdaIn, addrStrapBit2, addrStrapBit1, addrStrapBit0}),
      .syncOut(syncOut)
   );

   // Decoding
   assign sclS = syncOut[4];
   assign sdaS = syncOut[3];
   assign strapS = syncOut[2:0];
   wire sclRise = sclS && !sclP_q;
   wire sclFall = !sclS && sclP_q;
   wire startCond = sclS && sclP_q && sdaP_q && !sdaS;
   wire stopCond = sclS && sclP_q && !sdaP_q && sdaS;
   wire toutHit = (toutCnt_q == TOUT_LIM);
   wire byteDone = (bitCnt_q == `TSISP_BYTE_BITS);
   wire addrMatch = (shift_q[7:1] == {DEV_CODE, strapS});
   wire isRead = shift_q[0];
   wire [3:0] bitNext = bitCnt_q + 4'h1;

   always_comb
   begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      oe_d = sdaOe;
      firstRx_d = firstRx_q;
      nak_d = nak_q;
      ptr_d = regPtr;
      wrData_d = wrData;
      wrStb_d = 1'b0;
      rdTake_d = 1'b0;
      if (toutHit || stopCond)
      begin
         state_d = ST_IDLE;
         oe_d = 1'b0;
      end
      else if (startCond)
      begin
         state_d = ST_ADDR;
         bitCnt_d = `TSISP_BIT_ZERO;
         oe_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_ADDR:
            begin
               if (sclRise && !byteDone)
               begin
                  shift_d = {shift_q[6:0], sdaS};
                  bitCnt_d = bitNext;
               end
               else if (sclFall && byteDone)
               begin
                  bitCnt_d = `TSISP_BIT_ZERO;
                  if (addrMatch)
                  begin
                     state_d = ST_ADDR_ACK;
                     oe_d = 1'b1;
                  end
                  else
                     state_d = ST_IDLE;
               end
            end
            ST_ADDR_ACK:
            begin
               if (sclFall)
               begin
                  if (isRead)
                  begin
                     state_d = ST_TX;
                     shift_d = rdByte;
                     oe_d = !rdByte[7];
                     rdTake_d = 1'b1;
                  end
                  else
                  begin
                     state_d = ST_RX;
                     oe_d = 1'b0;
                     firstRx_d = 1'b1;
                  end
               end
            end
            ST_RX:
            begin
               if (sclRise && !byteDone)
               begin
                  shift_d = {shift_q[6:0], sdaS};
                  bitCnt_d = bitNext;
               end
               else if (sclFall && byteDone)
               begin
                  state_d = ST_RX_ACK;
                  oe_d = 1'b1;
                  bitCnt_d = `TSISP_BIT_ZERO;
                  if (firstRx_q)
                  begin
                     ptr_d = shift_q[`TSISP_PTR_W-1:0];
                     firstRx_d = 1'b0;
                  end
                  else
                  begin
                     wrData_d = shift_q;
                     wrStb_d = 1'b1;
                  end
               end
            end
            ST_RX_ACK:
            begin
               if (sclFall)
               begin
                  state_d = ST_RX;
                  oe_d = 1'b0;
               end
            end
            ST_TX:
            begin
               if (sclRise && !byteDone)
                  bitCnt_d = bitNext;
               else if (sclFall)
               begin
                  if (byteDone)
                  begin
                     state_d = ST_TX_ACK;
                     oe_d = 1'b0;
                     bitCnt_d = `TSISP_BIT_ZERO;
                  end
                  else
                  begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = !shift_q[6];
                  end
               end
            end
            ST_TX_ACK:
            begin
               if (sclRise)
                  nak_d = sdaS;
               else if (sclFall)
               begin
                  if (nak_q)
                     state_d = ST_IDLE;
                  else
                  begin
                     state_d = ST_TX;
                     shift_d = rdByte;
                     oe_d = !rdByte[7];
                     rdTake_d = 1'b1;
                  end
               end
            end
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         state_q <= ST_IDLE;
         bitCnt_q <= `TSISP_BIT_ZERO;
         shift_q <= 8'h00;
         sdaOe <= 1'b0;
         firstRx_q <= 1'b0;
         nak_q <= 1'b0;
         regPtr <= 4'h0;
         wrData <= 8'h00;
         wrStrobe <= 1'b0;
         rdTake <= 1'b0;
      end
      else
      begin
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         sdaOe <= oe_d;
         firstRx_q <= firstRx_d;
         nak_q <= nak_d;
         regPtr <= ptr_d;
         wrData <= wrData_d;
         wrStrobe <= wrStb_d;
         rdTake <= rdTake_d;
      end
   end

   // Stuck clock timer
   always_ff @(posedge clk)
   begin
      if (!reset_n || sclRise || sclFall || state_q == ST_IDLE)
         toutCnt_q <= '0;
      else if (!toutHit)
         toutCnt_q <= toutCnt_q + 1'b1;
   end

   // Open-drain pins only pull low
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sdaOut <= 1'b0;
         alertOut <= 1'b0;
         alertOe <= 1'b0;
      end
      else
      begin
         sdaOut <= 1'b0;
         alertOut <= 1'b0;
         alertOe <= overTemp;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   addr_reject_a: assert property (sclFall && state_q == ST_ADDR && byteDone && !addrMatch
      && !startCond && !stopCond && !toutHit |=> state_q == ST_IDLE && !sdaOe)
      else $error("foreign address not ignored");
   rx_ack_a: assert property (sclFall && state_q == ST_RX && byteDone && !startCond
      && !stopCond && !toutHit |=> sdaOe && state_q == ST_RX_ACK)
      else $error("received byte not acknowledged");
   sda_timing_a: assert property ($changed(sdaOe) |-> $past(sclFall)
      || $past(startCond) || $past(stopCond) || $past(toutHit))
      else $error("data changed outside clock low");
   ptr_hold_a: assert property ($changed(regPtr) |-> $past(state_q) == ST_RX
      && $past(firstRx_q) && $past(sclFall))
      else $error("pointer changed without pointer write");
   ptr_low_a: assert property (state_q == ST_RX && firstRx_q && byteDone && sclFall
      && !startCond && !stopCond && !toutHit |=> regPtr == $past(shift_q[3:0]))
      else $error("pointer not loaded from low nibble");
   start_abandon_a: assert property (startCond && !stopCond && !toutHit
      |=> state_q == ST_ADDR && !sdaOe && bitCnt_q == 4'h0)
      else $error("start did not restart transfer");
   stop_release_a: assert property (stopCond |=> state_q == ST_IDLE && !sdaOe)
      else $error("stop did not release bus");
   tout_reset_a: assert property (toutHit |=> state_q == ST_IDLE && !sdaOe)
      else $error("timeout did not reset port");
   nak_release_a: assert property (sclFall && state_q == ST_TX_ACK && nak_q && !startCond
      && !stopCond && !toutHit |=> state_q == ST_IDLE && !sdaOe)
      else $error("data line held after not-acknowledge");
   alert_drive_a: assert property (overTemp |=> alertOe && !alertOut)
      else $error("alert not driven");
   read_dir_a: assert property (state_q == ST_ADDR_ACK && sclFall && isRead && !startCond
      && !stopCond && !toutHit |=> state_q == ST_TX && rdTake)
      else $error("read direction not honoured");

   write_cov: cover property (wrStrobe);
   read_cov: cover property (rdTake ##[1:1000] state_q == ST_TX_ACK);
   ptr_cov: cover property ($changed(regPtr));
   tout_cov: cover property (toutHit);
endmodule

// ### tb/tsisp_master_model.sv
// Behavioural bus master for the two-wire slave port
`timescale 1ns/10ps
module tsisp_master_model (
   // Bus lines
   input wire logic sdaWire,
   output logic sclOut,
   output logic sdaLow
);
   localparam int HALF = 200;
   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   // Start from idle or repeated start; clock stands high between frames
   task automatic start_cond();
      sdaLow = 1'b0;
      #(HALF);
      sclOut = 1'b1;
      #(HALF);
      sdaLow = 1'b1;
      #(HALF);
      sclOut = 1'b0;
   endtask
   // Stop, then bus-free gap
   task automatic stop_cond();
      #50;
      sdaLow = 1'b1;
      #150;
      sclOut = 1'b1;
      #(HALF);
      sdaLow = 1'b0;
      #1400;
   endtask
   // One bit: data set while clock low, sampled late in the high phase
   task automatic xfer_bit(input logic txBit, output logic rxBit);
      #50;
      sdaLow = !txBit;
      #150;
      sclOut = 1'b1;
      #150;
      rxBit = sdaWire;
      #50;
      sclOut = 1'b0;
   endtask
   // Byte MSB first plus acknowledge slot; txAck high releases the line
   task automatic xfer_byte(input logic [7:0] txByte, input logic txAck,
      output logic [7:0] rxByte, output logic rxAck);
      for (int i = 7; i >= 0; i--)
      begin
         xfer_bit(txByte[i], rxByte[i]);
      end
      xfer_bit(txAck, rxAck);
   endtask
endmodule

// ### tb/tsisp_slave_bench.sv
// Self-checking bench of the two-wire slave port
`timescale 1ns/10ps
module tsisp_slave_bench;
   import tsisp_pkg::*;
   localparam int TOUT = 200;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sclLine;
   logic mstLow;
   logic sdaOut, sdaOe, alertOut, alertOe, wrStrobe, rdTake;
   logic altOut, altOe;
   logic [2:0] strap = 3'h5;
   logic overTemp = 1'b0;
   tsisp_ptr_t regPtr;
   tsisp_byte_t wrData, lastWr;
   tsisp_byte_t rdByte = 8'h3C;
   logic [7:0] rx;
   logic ack;
   int num_errors = 0;
   int checks = 0;
   int strobes = 0;
   wire sdaWire = !((sdaOe && !sdaOut) || (altOe && !altOut) || mstLow);
   wire alertWire = !(alertOe && !alertOut);
   always #25 clk = !clk;
   // Captures written bytes and presents the inverted byte after each load
   always @(posedge clk)
   begin
      if (wrStrobe === 1'b1)
      begin
         strobes++;
         lastWr = wrData;
      end
      if (rdTake === 1'b1)
         rdByte <= #1 ~rdByte;
   end
   tsisp_slave #(.TOUT_CYC(TOUT)) dut_u (.clk(clk), .reset_n(reset_n),
      .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addrStrapBit0(strap[0]), .addrStrapBit1(strap[1]), .addrStrapBit2(strap[2]),
      .overTemp(overTemp), .alertOut(alertOut), .alertOe(alertOe), .regPtr(regPtr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdByte(rdByte), .rdTake(rdTake));
   // Second port with the alternate address code on the same bus
   tsisp_slave #(.ALT_CODE(1'b1), .TOUT_CYC(TOUT)) dut_alt_u (.clk(clk), .reset_n(reset_n),
      .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(altOut), .sdaOe(altOe),
      .addrStrapBit0(!strap[0]), .addrStrapBit1(strap[1]), .addrStrapBit2(strap[2]),
      .overTemp(overTemp), .alertOut(), .alertOe(), .regPtr(), .wrData(), .wrStrobe(),
      .rdByte(8'h96), .rdTake());
   tsisp_master_model mst_u (.sdaWire(sdaWire), .sclOut(sclLine), .sdaLow(mstLow));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic test_write();
      mst_u.start_cond();
      mst_u.xfer_byte({4'h3, strap, 1'b0}, 1'b1, rx, ack);
      check(ack, 1'b0, "address ack");
      mst_u.xfer_byte(8'h05, 1'b1, rx, ack);
      check(ack, 1'b0, "pointer ack");
      check(regPtr, 4'h5, "pointer");
      mst_u.xfer_byte(8'hA5, 1'b1, rx, ack);
      check(ack, 1'b0, "data ack");
      check(lastWr, 8'hA5, "data");
      mst_u.xfer_byte(8'h5A, 1'b1, rx, ack);
      check(lastWr, 8'h5A, "second data");
      check(8'(strobes), 8'h02, "strobe count");
      check(regPtr, 4'h5, "pointer kept");
      mst_u.stop_cond();
      check(sdaWire, 1'b1, "released after stop");
   endtask
   task automatic test_read();
      mst_u.start_cond();
      mst_u.xfer_byte({4'h3, strap, 1'b1}, 1'b1, rx, ack);
      check(ack, 1'b0, "read address ack");
      mst_u.xfer_byte(8'hFF, 1'b0, rx, ack);
      check(rx, 8'h3C, "first read byte");
      mst_u.xfer_byte(8'hFF, 1'b1, rx, ack);
      check(rx, 8'hC3, "second read byte");
      check(regPtr, 4'h5, "pointer kept on read");
      #300;
      check(sdaOe, 1'b0, "released after nak");
      mst_u.stop_cond();
   endtask
   task automatic test_wrong_addr();
      logic [7:0] addrs [2];
      addrs = '{{4'h9, strap, 1'b0}, {4'h3, strap ^ 3'h2, 1'b0}};
      for (int i = 0; i < 2; i++)
      begin
         mst_u.start_cond();
         mst_u.xfer_byte(addrs[i], 1'b1, rx, ack);
         check(ack, 1'b1, "foreign address");
         mst_u.stop_cond();
      end
      mst_u.start_cond();
      mst_u.xfer_byte({4'h9, strap ^ 3'h1, 1'b0}, 1'b1, rx, ack);
      check(ack, 1'b0, "alternate code");
      mst_u.stop_cond();
   endtask
   task automatic test_abort();
      mst_u.start_cond();
      mst_u.xfer_byte({4'h3, strap, 1'b0}, 1'b1, rx, ack);
      for (int i = 0; i < 4; i++)
      begin
         mst_u.xfer_bit(1'b0, ack);
      end
      mst_u.start_cond();
      mst_u.xfer_byte({4'h3, strap, 1'b1}, 1'b1, rx, ack);
      check(ack, 1'b0, "address after restart");
      mst_u.xfer_byte(8'hFF, 1'b0, rx, ack);
      check(rx, 8'h3C, "read after restart");
      mst_u.xfer_byte(8'hFF, 1'b1, rx, ack);
      check(rx, 8'hC3, "next read after restart");
      check(regPtr, 4'h5, "partial pointer dropped");
      mst_u.stop_cond();
   endtask
   task automatic test_timeout();
      mst_u.start_cond();
      mst_u.xfer_byte({4'h3, strap, 1'b1}, 1'b1, rx, ack);
      #300;
      check(sdaOe, 1'b1, "first bit driven low");
      repeat (TOUT - 10) @(posedge clk);
      #1 check(sdaOe, 1'b1, "held before time-out");
      repeat (50) @(posedge clk);
      #1 check(sdaOe, 1'b0, "released on stuck clock");
      mst_u.stop_cond();
   endtask
   task automatic test_alert();
      @(posedge clk) #1 overTemp = 1'b1;
      @(posedge clk) #1 check(alertWire, 1'b0, "alert pulled low");
      overTemp = 1'b0;
      @(posedge clk) #1 check(alertWire, 1'b1, "alert released");
   endtask
   initial
   begin
      for (int i = 0; i < 20000; i++)
      begin
         @(posedge clk);
      end
      num_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 test_write();
      test_read();
      test_wrong_addr();
      test_abort();
      test_timeout();
      test_alert();
      print_verdict();
   end
endmodule
